// ===== kmp_regs.svh
`ifndef KMP_REGS_SVH
`define KMP_REGS_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define KMP_OFS_DRIVE 24'h00FE86
`define KMP_OFS_SENSE 24'h00FE88
`define KMP_DRIVE_RST 8'h47

// ----------------------------------------
// field positions, shared by both registers
// ----------------------------------------
`define KMP_POS_DATA_CH1 0
`define KMP_POS_DATA_CH2 1
`define KMP_POS_DATA_CH3 2
`define KMP_POS_TIMING_CH1 3
`define KMP_POS_TIMING_CH2 4
`define KMP_POS_TIMING_CH3 5
`define KMP_POS_DATA_CH4 6
`define KMP_POS_TIMING_CH4 7

`endif

// ===== kmp_pkg.sv
`include "kmp_regs.svh"

package kmp_pkg;

   // ----------------------------------------
   // widths and register types
   // ----------------------------------------
   typedef logic [23:0] kmp_addr_t;
   typedef logic [7:0] kmp_byte_t;
   typedef logic [3:0] kmp_chan_t;

   // system-domain state of the top module
   typedef struct packed
   {
      kmp_byte_t drive;
      kmp_byte_t rdata;
      logic eng_reset;
      kmp_chan_t active;
      kmp_chan_t pull_data;
      kmp_chan_t pull_timing;
   } kmp_sys_s;

   // link-domain state of the pin driver
   typedef struct packed
   {
      logic rst_s1;
      logic rst_s2;
      kmp_chan_t data_s1;
      kmp_chan_t data_s2;
      kmp_chan_t timing_s1;
      kmp_chan_t timing_s2;
      kmp_chan_t oe_data;
      kmp_chan_t oe_timing;
   } kmp_link_s;

   // ----------------------------------------
   // byte layout helpers
   // ----------------------------------------
   function automatic kmp_chan_t kmp_data_bits(input kmp_byte_t r);
      kmp_chan_t d;
      d[0] = r[`KMP_POS_DATA_CH1];
      d[1] = r[`KMP_POS_DATA_CH2];
      d[2] = r[`KMP_POS_DATA_CH3];
      d[3] = r[`KMP_POS_DATA_CH4];
      return d;
   endfunction

   function automatic kmp_chan_t kmp_timing_bits(input kmp_byte_t r);
      kmp_chan_t c;
      c[0] = r[`KMP_POS_TIMING_CH1];
      c[1] = r[`KMP_POS_TIMING_CH2];
      c[2] = r[`KMP_POS_TIMING_CH3];
      c[3] = r[`KMP_POS_TIMING_CH4];
      return c;
   endfunction

   function automatic kmp_byte_t kmp_pack(input kmp_chan_t d, input kmp_chan_t c);
      kmp_byte_t r;
      r = 8'h00;
      r[`KMP_POS_DATA_CH1] = d[0];
      r[`KMP_POS_DATA_CH2] = d[1];
      r[`KMP_POS_DATA_CH3] = d[2];
      r[`KMP_POS_DATA_CH4] = d[3];
      r[`KMP_POS_TIMING_CH1] = c[0];
      r[`KMP_POS_TIMING_CH2] = c[1];
      r[`KMP_POS_TIMING_CH3] = c[2];
      r[`KMP_POS_TIMING_CH4] = c[3];
      return r;
   endfunction

endpackage

// ===== kmp_pull_if.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// pull-low requests from system to link domain
// ----------------------------------------
interface kmp_pull_if;
   logic [3:0] pull_data;
   logic [3:0] pull_timing;

   modport sys (output pull_data, output pull_timing);
   modport link (input pull_data, input pull_timing);
endinterface

`default_nettype wire

// ===== kmp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// two-flop level synchroniser
// ----------------------------------------
module kmp_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } kmp_sync_s;

   kmp_sync_s state_ff;
   kmp_sync_s nxt_state;

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_state.s1 = async_in;
      nxt_state.s2 = state_ff.s1;
      if (rst)
      begin
         nxt_state = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      state_ff <= nxt_state;
   end

   assign sync_out = state_ff.s2;
endmodule

`default_nettype wire

// ===== kmp_link.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// open-drain pin driver on the link clock
// ----------------------------------------
module kmp_link (
   // link clock, system reset crosses in
   input wire logic link_clk,
   input wire logic rst,
   // requests from the system domain
   kmp_pull_if.link pull,
   // open-drain enables, high pulls the line low
   output logic [3:0] data_oe,
   output logic [3:0] timing_oe
);
   import kmp_pkg::*;

   kmp_link_s state_ff;
   kmp_link_s nxt_state;

   // each line is an independent level, so per-bit two-flop crossing is safe
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.rst_s1 = rst;
      nxt_state.rst_s2 = state_ff.rst_s1;
      nxt_state.data_s1 = pull.pull_data;
      nxt_state.data_s2 = state_ff.data_s1;
      nxt_state.timing_s1 = pull.pull_timing;
      nxt_state.timing_s2 = state_ff.timing_s1;
      nxt_state.oe_data = state_ff.data_s2;
      nxt_state.oe_timing = state_ff.timing_s2;
      // lines released while reset is seen on this side
      if (state_ff.rst_s2)
      begin
         nxt_state.oe_data = 4'h0;
         nxt_state.oe_timing = 4'h0;
      end
   end

   always_ff @(posedge link_clk)
   begin
      state_ff <= nxt_state;
   end

   assign data_oe = state_ff.oe_data;
   assign timing_oe = state_ff.oe_timing;
endmodule

`default_nettype wire

// ===== kmp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "kmp_regs.svh"

module kmp_top (
   // system clock and reset
   input wire logic clk,
   input wire logic rst,
   // link clock for the pin drivers
   input wire logic link_clk,
   // register port
   input wire kmp_pkg::kmp_addr_t addr,
   input wire kmp_pkg::kmp_byte_t wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output kmp_pkg::kmp_byte_t rdata,
   // shift engine side
   input wire logic eng_enable,
   input wire logic eng_tx_mode,
   input wire kmp_pkg::kmp_chan_t eng_tx_active_entry,
   input wire kmp_pkg::kmp_chan_t eng_data_low,
   input wire kmp_pkg::kmp_chan_t eng_timing_low,
   output logic eng_reset,
   output kmp_pkg::kmp_chan_t chan_active,
   output kmp_pkg::kmp_chan_t sense_data,
   output kmp_pkg::kmp_chan_t sense_timing,
   // data lines, open drain
   input wire kmp_pkg::kmp_chan_t port_data_line_in,
   output kmp_pkg::kmp_chan_t port_data_line_out,
   output kmp_pkg::kmp_chan_t port_data_line_oe,
   // timing lines, open drain
   input wire kmp_pkg::kmp_chan_t port_timing_line_in,
   output kmp_pkg::kmp_chan_t port_timing_line_out,
   output kmp_pkg::kmp_chan_t port_timing_line_oe
);
   import kmp_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   kmp_sys_s state_ff;
   kmp_sys_s nxt_state;
   kmp_byte_t line_raw;
   kmp_byte_t line_sync;
   kmp_chan_t drv_data;
   kmp_chan_t drv_timing;
   kmp_chan_t hw_set;
   logic wr_drive;
   logic rd_drive;
   logic rd_sense;

   kmp_pull_if pull ();

   // ----------------------------------------
   // line sensing
   // ----------------------------------------

   // pins gathered in register layout before crossing
   assign line_raw = kmp_pack(port_data_line_in, port_timing_line_in);

   // pins are asynchronous to clk, so two flops before any reader
   kmp_sync #(
      .W(8)
   ) u_sense_sync (
      .clk(clk),
      .rst(rst),
      .async_in(line_raw),
      .sync_out(line_sync)
   );

   // synchronised levels also serve the shift engine
   assign sense_data = kmp_data_bits(line_sync);
   assign sense_timing = kmp_timing_bits(line_sync);

   // ----------------------------------------
   // address decode
   // ----------------------------------------

   // strobes never overlap, so each decode stands alone
   assign wr_drive = wr_stb && (addr == `KMP_OFS_DRIVE);
   assign rd_drive = rd_stb && (addr == `KMP_OFS_DRIVE);
   assign rd_sense = rd_stb && (addr == `KMP_OFS_SENSE);

   // ----------------------------------------
   // field views of the drive register
   // ----------------------------------------

   // channel order is 1..4 in bit 0..3 of each view
   assign drv_data = kmp_data_bits(state_ff.drive);
   assign drv_timing = kmp_timing_bits(state_ff.drive);

   // transmit-active entry only counts in transmit mode on an active channel
   assign hw_set = eng_tx_active_entry & state_ff.active & {4{eng_tx_mode}};

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb
   begin
      nxt_state = state_ff;

      // software write of the drive register
      if (wr_drive)
      begin
         nxt_state.drive = wdata;
      end

      // hardware release of the data line after the start bit;
      // applied after the write so the set wins over a same-cycle clear
      if (hw_set[0])
      begin
         nxt_state.drive[`KMP_POS_DATA_CH1] = 1'b1;
      end
      if (hw_set[1])
      begin
         nxt_state.drive[`KMP_POS_DATA_CH2] = 1'b1;
      end
      if (hw_set[2])
      begin
         nxt_state.drive[`KMP_POS_DATA_CH3] = 1'b1;
      end
      if (hw_set[3])
      begin
         nxt_state.drive[`KMP_POS_DATA_CH4] = 1'b1;
      end

      // read data stands only in the cycle after the strobe
      nxt_state.rdata = 8'h00;
      if (rd_drive)
      begin
         nxt_state.rdata = state_ff.drive;
      end
      else if (rd_sense)
      begin
         nxt_state.rdata = line_sync;
      end

      // all timing bits low holds the shift engine in reset
      nxt_state.eng_reset = (kmp_timing_bits(nxt_state.drive) == 4'h0);

      // channel selection only means something with the engine on
      nxt_state.active = kmp_timing_bits(nxt_state.drive) & {4{eng_enable}};

      // a cleared data bit pulls low in either mode; in engine mode that is
      // the firmware's transmit request, otherwise plain bit control
      nxt_state.pull_data = ~kmp_data_bits(nxt_state.drive);
      if (eng_enable)
      begin
         nxt_state.pull_data = nxt_state.pull_data | (eng_data_low & nxt_state.active);
      end

      // a cleared timing bit always pulls low; a set one releases the line
      // unless the enabled engine wants it low on that channel
      nxt_state.pull_timing = ~kmp_timing_bits(nxt_state.drive);
      if (eng_enable)
      begin
         nxt_state.pull_timing = nxt_state.pull_timing | (eng_timing_low & nxt_state.active);
      end

      // synchronous reset: lines as the reset drive value implies
      if (rst)
      begin
         nxt_state.drive = `KMP_DRIVE_RST;
         nxt_state.rdata = 8'h00;
         nxt_state.eng_reset = 1'b1;
         nxt_state.active = 4'h0;
         nxt_state.pull_data = 4'h0;
         nxt_state.pull_timing = 4'hF;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      state_ff <= nxt_state;
   end

   // ----------------------------------------
   // outputs to the shift engine and bus
   // ----------------------------------------
   assign rdata = state_ff.rdata;
   assign eng_reset = state_ff.eng_reset;
   assign chan_active = state_ff.active;

   // ----------------------------------------
   // pin drive through the link domain
   // ----------------------------------------

   // pull requests are registered here, so the crossing sees clean levels
   assign pull.pull_data = state_ff.pull_data;
   assign pull.pull_timing = state_ff.pull_timing;

   // the pin driver adds about three link clocks of latency; a line change
   // is therefore visible roughly 375 ns after the write at bench rates
   kmp_link u_link (
      .link_clk(link_clk),
      .rst(rst),
      .pull(pull.link),
      .data_oe(port_data_line_oe),
      .timing_oe(port_timing_line_oe)
   );

   // open drain: the driven level is always low, released means pulled up
   assign port_data_line_out = 4'h0;
   assign port_timing_line_out = 4'h0;
endmodule

`default_nettype wire

// ===== kmp_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "kmp_regs.svh"

// ----------------------------------------
// port checks of the line register block
// ----------------------------------------
module kmp_top_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire kmp_pkg::kmp_addr_t addr,
   input wire kmp_pkg::kmp_byte_t wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire kmp_pkg::kmp_byte_t rdata,
   // engine side
   input wire logic eng_enable,
   input wire logic eng_tx_mode,
   input wire kmp_pkg::kmp_chan_t eng_tx_active_entry,
   input wire kmp_pkg::kmp_chan_t eng_data_low,
   input wire logic eng_reset,
   input wire kmp_pkg::kmp_chan_t chan_active,
   input wire kmp_pkg::kmp_chan_t sense_data,
   input wire kmp_pkg::kmp_chan_t sense_timing,
   // pins
   input wire kmp_pkg::kmp_chan_t port_data_line_in,
   input wire kmp_pkg::kmp_chan_t port_data_line_out,
   input wire kmp_pkg::kmp_chan_t port_data_line_oe,
   input wire kmp_pkg::kmp_chan_t port_timing_line_in,
   input wire kmp_pkg::kmp_chan_t port_timing_line_out,
   input wire kmp_pkg::kmp_chan_t port_timing_line_oe
);
   import kmp_pkg::*;
   localparam kmp_addr_t DRV = `KMP_OFS_DRIVE;
   localparam kmp_addr_t SNS = `KMP_OFS_SENSE;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // steps of a register access
   sequence drv_wr;
      wr_stb && addr == DRV;
   endsequence
   sequence drv_rd;
      rd_stb && addr == DRV && !eng_tx_mode;
   endsequence

   // ----------------------------------------
   // register port
   // ----------------------------------------
   rdata_idle_a: assert property (
      (!rd_stb || (addr != DRV && addr != SNS)) |=> rdata == 8'h00)
      else $error("read data not idle");
   drive_back_a: assert property (drv_wr ##1 !wr_stb ##1 drv_rd |=> rdata == $past(wdata, 3))
      else $error("drive register readback wrong");
   sense_map_a: assert property (
      rd_stb && addr == SNS ##1 $stable(sense_data) && $stable(sense_timing)
      |-> rdata == {sense_timing[3], sense_data[3], sense_timing[2:0], sense_data[2:0]})
      else $error("sense layout wrong");
   // slack of two edges tolerates up to two output stages behind the two flops
   sync_delay_a: assert property (
      $stable(port_data_line_in)[*4] |-> sense_data == port_data_line_in)
      else $error("sensed level late");
   sync_timing_a: assert property (
      $stable(port_timing_line_in)[*4] |-> sense_timing == port_timing_line_in)
      else $error("sensed timing level late");

   // ----------------------------------------
   // engine controls
   // ----------------------------------------
   eng_reset_a: assert property (drv_wr |=> eng_reset == !$past(|(wdata & 8'hB8)))
      else $error("engine reset wrong");
   active_map_a: assert property (
      drv_wr ##1 $stable(eng_enable)
      |-> chan_active == ({$past(wdata[7]), $past(wdata[5:3])} & {4{eng_enable}}))
      else $error("active channels wrong");

   // ----------------------------------------
   // open-drain pins
   // ----------------------------------------
   open_drain_a: assert property (port_data_line_out == 4'h0 && port_timing_line_out == 4'h0)
      else $error("pin driven high");
   data_pull_a: assert property (
      drv_wr ##0 !eng_enable && !wdata[0] |-> ##[1:14] port_data_line_oe[0])
      else $error("data line not pulled");
   timing_pull_a: assert property (drv_wr ##0 !wdata[3] |-> ##[1:14] port_timing_line_oe[0])
      else $error("timing line not pulled");
   timing_free_a: assert property (
      drv_wr ##0 !eng_enable && wdata[3] |-> ##[1:14] !port_timing_line_oe[0])
      else $error("timing line not released");
   tx_set_a: assert property (
      eng_tx_active_entry[0] && eng_tx_mode && chan_active[0] && eng_data_low == 4'h0
      |-> ##[1:14] !port_data_line_oe[0])
      else $error("data line not set by hardware");
endmodule

bind kmp_top kmp_top_assertions i_kmp_top_assertions (.*);

`default_nettype wire

// ===== kmp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// attached devices with pull-ups on the lines
// ----------------------------------------
module kmp_dev_model (
   // enables from the controller
   input wire kmp_pkg::kmp_chan_t data_oe,
   input wire kmp_pkg::kmp_chan_t timing_oe,
   // pulls made by the devices
   input wire kmp_pkg::kmp_chan_t dev_data_pull,
   input wire kmp_pkg::kmp_chan_t dev_timing_pull,
   // resolved levels
   output kmp_pkg::kmp_chan_t data_line,
   output kmp_pkg::kmp_chan_t timing_line
);
   import kmp_pkg::*;
   // pull-up wins unless either side pulls low
   assign data_line = ~(data_oe | dev_data_pull);
   assign timing_line = ~(timing_oe | dev_timing_pull);
endmodule

`default_nettype wire

// ===== kmp_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "kmp_regs.svh"

module kmp_top_bench;
   import kmp_pkg::*;
   localparam kmp_addr_t DRV = `KMP_OFS_DRIVE;
   localparam kmp_addr_t SNS = `KMP_OFS_SENSE;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   kmp_addr_t addr = 24'h000000;
   kmp_byte_t wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic eng_enable = 1'b0;
   logic eng_tx_mode = 1'b0;
   kmp_chan_t eng_tx_active_entry = 4'h0;
   kmp_chan_t eng_data_low = 4'h0;
   kmp_chan_t eng_timing_low = 4'h0;
   kmp_chan_t dev_data_pull = 4'h0;
   kmp_chan_t dev_timing_pull = 4'h0;
   kmp_byte_t rdata, d, v;
   logic eng_reset;
   kmp_chan_t chan_active, sense_data, sense_timing, port_data_line_out, port_timing_line_out;
   kmp_chan_t port_data_line_in, port_data_line_oe, port_timing_line_in, port_timing_line_oe;
   int failures = 0;
   int samples_checked = 0;

   kmp_top i_kmp_top (.*);
   kmp_dev_model i_kmp_dev_model (.data_oe(port_data_line_oe), .timing_oe(port_timing_line_oe),
      .dev_data_pull(dev_data_pull), .dev_timing_pull(dev_timing_pull),
      .data_line(port_data_line_in), .timing_line(port_timing_line_in));

   // ----------------------------------------
   // clocks, the link one offset in phase
   // ----------------------------------------
   initial
   begin
      forever #25 clk = ~clk;
   end
   initial
   begin
      #17;
      forever #62.5 link_clk = ~link_clk;
   end

   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input kmp_addr_t a, input kmp_byte_t x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // data stand one cycle only, so take them mid-cycle
   task rd(input kmp_addr_t a, output kmp_byte_t x);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      x = rdata;
   endtask
   task chk(input string nm, input kmp_byte_t got, input kmp_byte_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wrap_up;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence; the link pipeline settles from the pull levels alone
   // ----------------------------------------
   initial
   begin
      wt(2);
      rst <= 1'b0;
      wt(20);
      rd(DRV, d);
      chk("drive reset", d, 8'h47);
      chk("engine reset", {7'h00, eng_reset}, 8'h01);
      rd(24'h00FE87, d);
      chk("unmapped", d, 8'h00);
      rd(SNS, d);
      chk("sense reset", d, 8'h47);
      for (int i = 0; i < 8; i++)
      begin
         v = ~(8'h01 << i);
         wr(DRV, v);
         rd(DRV, d);
         chk("drive", d, v);
         wt(16);
         chk("data oe", {4'h0, port_data_line_oe}, {4'h0, ~{v[6], v[2:0]}});
         chk("timing oe", {4'h0, port_timing_line_oe}, {4'h0, ~{v[7], v[5:3]}});
         rd(SNS, d);
         chk("sense", d, v);
      end
      // sense is read only; devices pull released lines
      wr(SNS, 8'h00);
      dev_data_pull <= 4'hA;
      dev_timing_pull <= 4'h5;
      wt(8);
      rd(SNS, d);
      chk("pulled sense", d, 8'h15);
      rd(DRV, d);
      chk("drive kept", d, 8'h7F);
      wt(1);
      dev_data_pull <= 4'h0;
      dev_timing_pull <= 4'h0;
      eng_enable <= 1'b1;
      wr(DRV, 8'h6F);
      wt(1);
      chk("active", {4'h0, chan_active}, 8'h05);
      chk("engine run", {7'h00, eng_reset}, 8'h00);
      eng_data_low <= 4'hF;
      eng_timing_low <= 4'hF;
      wt(16);
      chk("engine data oe", {4'h0, port_data_line_oe}, 8'h05);
      chk("engine timing oe", {4'h0, port_timing_line_oe}, 8'h0F);
      eng_data_low <= 4'h0;
      eng_timing_low <= 4'h0;
      eng_tx_mode <= 1'b1;
      // firmware signals a transmit request on ch1 and ch2
      wr(DRV, 8'h6C);
      wt(16);
      chk("request oe", {4'h0, port_data_line_oe}, 8'h03);
      eng_tx_active_entry <= 4'h3;
      wt(1);
      eng_tx_active_entry <= 4'h0;
      rd(DRV, d);
      chk("hardware set", d, 8'h6D);
      // hardware set and a software clear of ch1 data in the same cycle
      @(posedge clk);
      addr <= DRV;
      wdata <= 8'h6C;
      wr_stb <= 1'b1;
      eng_tx_active_entry <= 4'h1;
      @(posedge clk);
      wr_stb <= 1'b0;
      eng_tx_active_entry <= 4'h0;
      rd(DRV, d);
      chk("set beats clear", d, 8'h6D);
      // ch2 abandoned: release its data before dropping it
      wr(DRV, 8'h6F);
      wr(DRV, 8'h47);
      wt(2);
      chk("all off reset", {7'h00, eng_reset}, 8'h01);
      chk("none active", {4'h0, chan_active}, 8'h00);
      wt(16);
      wrap_up;
   end

   // ----------------------------------------
   // watchdog well beyond the few hundred cycles needed
   // ----------------------------------------
   initial
   begin
      wt(3000);
      failures++;
      wrap_up;
   end
endmodule

`default_nettype wire
